// ### logic/ssli_top.sv
// Settings register, indicator pattern generator and noise map selection
`timescale 1ns/10ps
module ssli_top (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic set_we_i,
    input wire ssli_pkg::ssli_settings_t set_data_i,
    input wire logic profile_start_i,
    input wire logic [2:0] state_i,
    input wire logic fail_safe_i,
    input wire logic [6:0] rpm_i,
    input wire logic stored_map_present_i,
    input wire logic [15:0] stored_map_zone_i,
    input wire logic [15:0] zone_cfg_i,
    input wire logic adapt_suppress_i,
    output ssli_pkg::ssli_settings_t settings_o,
    output logic set_reject_o,
    output ssli_pkg::ssli_rgb_t led_o,
    output logic band_high_o,
    output ssli_pkg::ssli_map_t map_src_slow_o,
    output ssli_pkg::ssli_map_t map_src_fast_o,
    output logic map_save_o,
    output logic adapt_en_slow_o,
    output logic adapt_en_fast_o,
    output logic error_hold_o,
    output ssli_pkg::ssli_valid_t valid_o
);
    logic rst_s1_ff;
    logic rst_b_ff;
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_s1_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_b_ff <= rst_s1_ff;
        end
    end

    // Settings store with range check
    ssli_pkg::ssli_settings_t set_ff;
    wire set_ok = (set_data_i.sensitivity <= ssli_pkg::SENS_MAX) && (set_data_i.led_mode != 2'h3); // [RQ1] [RQ2]
    always_ff @(posedge clock_i or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            set_ff <= '{ssli_pkg::SENS_RST, ssli_pkg::MODE_RST, ssli_pkg::BAND_RST,
                        ssli_pkg::USE_STORED_RST, ssli_pkg::USE_DEFAULT_RST, ssli_pkg::ADAPT_RST}; // [RQ18]
            set_reject_o <= 1'b0;
        end
        else
        begin
            if (set_we_i && set_ok)
                set_ff <= set_data_i;
            set_reject_o <= set_we_i && !set_ok;
        end
    end
    assign settings_o = set_ff;
    assign band_high_o = set_ff.band_high; // [RQ9]

    // Operating state and error latch
    wire ssli_pkg::ssli_state_t st = ssli_pkg::ssli_state_t'(state_i);
    logic err_ff;
    always_ff @(posedge clock_i or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
            err_ff <= 1'b0;
        else if (st == ssli_pkg::SSLI_ERROR)
            err_ff <= 1'b1;
        else if (profile_start_i)
            err_ff <= 1'b0; // [RQ19]
    end
    assign error_hold_o = err_ff;

    // Output validity per state
    wire valid_mov = !err_ff && (st == ssli_pkg::SSLI_NOMOV || st == ssli_pkg::SSLI_MOV
                     || st == ssli_pkg::SSLI_TRACK || st == ssli_pkg::SSLI_BREATH); // [RQ20]
    wire valid_tgt = !err_ff && (st == ssli_pkg::SSLI_MOV || st == ssli_pkg::SSLI_TRACK
                     || st == ssli_pkg::SSLI_BREATH); // [RQ21]
    wire valid_rsp = !err_ff && (st == ssli_pkg::SSLI_BREATH); // [RQ22]
    always_ff @(posedge clock_i or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
            valid_o <= '0;
        else
            valid_o <= '{valid_mov, valid_tgt, valid_rsp};
    end

    // Noise map source chosen at profile start, shared by both maps
    wire stored_valid = stored_map_present_i && (stored_map_zone_i == zone_cfg_i); // [RQ13]
    wire ssli_pkg::ssli_map_t nxt_src = (set_ff.use_stored && stored_valid) ? ssli_pkg::SSLI_MAP_STORED // [RQ11]
                     : set_ff.use_default ? ssli_pkg::SSLI_MAP_DEFAULT // [RQ14] [RQ16]
                     : ssli_pkg::SSLI_MAP_BUILD; // [RQ15]
    ssli_pkg::ssli_map_t src_ff;
    logic save_pend_ff;
    logic in_init_ff;
    wire init_done = in_init_ff && (st != ssli_pkg::SSLI_INIT);
    always_ff @(posedge clock_i or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            src_ff <= ssli_pkg::SSLI_MAP_BUILD;
            save_pend_ff <= 1'b0;
            in_init_ff <= 1'b0;
            map_save_o <= 1'b0;
        end
        else
        begin
            in_init_ff <= (st == ssli_pkg::SSLI_INIT);
            map_save_o <= init_done && save_pend_ff && !err_ff; // [RQ12]
            if (profile_start_i)
            begin
                src_ff <= nxt_src;
                save_pend_ff <= set_ff.use_stored && !stored_valid && !set_ff.use_default; // [RQ12]
            end
            else if (init_done)
                save_pend_ff <= 1'b0;
        end
    end
    assign map_src_slow_o = src_ff; // [RQ10]
    assign map_src_fast_o = src_ff; // [RQ10]
    wire adapt = set_ff.adaptive && !adapt_suppress_i; // [RQ17]
    assign adapt_en_slow_o = adapt; // [RQ10]
    assign adapt_en_fast_o = adapt;

    // Indicator pattern timing
    logic [21:0] tick_cnt_ff;
    logic [5:0] step_ff;
    logic [18:0] bcnt_ff;
    logic bphase_ff;
    logic [2:0] st_q_ff;
    logic [1:0] mode_q_ff;
    wire restart = (st_q_ff != state_i) || (mode_q_ff != set_ff.led_mode); // [RQ24]
    wire tick = (tick_cnt_ff == 22'(ssli_pkg::STEP_CYC - 1)); // [RQ24]
    wire [5:0] pat_end = (st == ssli_pkg::SSLI_INIT) ? ssli_pkg::INIT_END
                       : (st == ssli_pkg::SSLI_NOMOV) ? ssli_pkg::NOMOV_END : ssli_pkg::HALF_END;
    // Half period of the breathing flash in 0.1 s steps: 300 / rpm
    wire [6:0] rpm_safe = (rpm_i == 7'h00) ? 7'h01 : rpm_i;
    wire [18:0] bhalf = ssli_pkg::HALF_MIN_STEPS / {12'h000, rpm_safe}; // [RQ4]
    always_ff @(posedge clock_i or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            tick_cnt_ff <= '0;
            step_ff <= '0;
            bcnt_ff <= '0;
            bphase_ff <= 1'b0;
            st_q_ff <= ssli_pkg::SSLI_INIT;
            mode_q_ff <= ssli_pkg::MODE_RST;
        end
        else
        begin
            st_q_ff <= state_i;
            mode_q_ff <= set_ff.led_mode;
            if (restart || tick)
                tick_cnt_ff <= '0;
            else
                tick_cnt_ff <= tick_cnt_ff + 22'h000001;
            if (restart)
            begin
                step_ff <= '0;
                bcnt_ff <= '0;
                bphase_ff <= 1'b1;
            end
            else if (tick)
            begin
                step_ff <= (step_ff + 6'h01 >= pat_end) ? 6'h00 : step_ff + 6'h01;
                if (bcnt_ff + 19'h00001 >= bhalf)
                begin
                    bcnt_ff <= '0;
                    bphase_ff <= !bphase_ff; // [RQ4]
                end
                else
                    bcnt_ff <= bcnt_ff + 19'h00001;
            end
        end
    end

    // Colour selection
    localparam ssli_pkg::ssli_rgb_t C_OFF = 3'h0;
    localparam ssli_pkg::ssli_rgb_t C_R = 3'h4;
    localparam ssli_pkg::ssli_rgb_t C_G = 3'h2;
    localparam ssli_pkg::ssli_rgb_t C_B = 3'h1;
    localparam ssli_pkg::ssli_rgb_t C_O = 3'h6;
    localparam ssli_pkg::ssli_rgb_t C_W = 3'h7;
    wire simple = (set_ff.led_mode == ssli_pkg::SSLI_SIMPLE);
    wire ssli_pkg::ssli_rgb_t c_init = (step_ff < ssli_pkg::INIT_B1) ? C_G
                       : (step_ff < ssli_pkg::INIT_B2) ? C_O
                       : (step_ff < ssli_pkg::INIT_B3) ? C_R
                       : (step_ff < ssli_pkg::INIT_B4) ? C_O
                       : (step_ff < ssli_pkg::INIT_B5) ? C_G : C_OFF; // [RQ3]
    wire first_half = (step_ff < ssli_pkg::HALF_B);
    wire ssli_pkg::ssli_rgb_t c_track = simple ? C_G : (first_half ? C_G : C_B); // [RQ5] [RQ8]
    wire ssli_pkg::ssli_rgb_t c_mov = simple ? C_O : (first_half ? C_G : C_O); // [RQ6] [RQ8]
    wire ssli_pkg::ssli_rgb_t c_breath = simple ? C_B : (bphase_ff ? C_B : C_OFF); // [RQ4] [RQ8]
    wire ssli_pkg::ssli_rgb_t c_nomov = (step_ff < ssli_pkg::NOMOV_B) ? C_R : C_OFF; // [RQ7]
    wire ssli_pkg::ssli_rgb_t c_state = (st == ssli_pkg::SSLI_INIT) ? c_init
                       : (st == ssli_pkg::SSLI_BREATH) ? c_breath
                       : (st == ssli_pkg::SSLI_TRACK) ? c_track
                       : (st == ssli_pkg::SSLI_MOV) ? c_mov
                       : (st == ssli_pkg::SSLI_NOMOV) ? c_nomov : C_OFF;
    wire ssli_pkg::ssli_rgb_t nxt_led = fail_safe_i ? C_W // [RQ23]
                       : (set_ff.led_mode == ssli_pkg::SSLI_OFF) ? C_OFF : c_state; // [RQ2]
    always_ff @(posedge clock_i or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
            led_o <= C_OFF;
        else
            led_o <= nxt_led;
    end
endmodule

// ### logic/ssli_pkg.sv
// Package of constants and types for the sensor settings and indicator block
// Function
// RQ1 - Sensitivity accepts integers 0 to 9; higher favours small targets.
// RQ2 - Indicator has full, simple and off modes; off keeps it dark.
// RQ3 - Initializing cycles green, orange, red, orange, green, dark with printed times.
// RQ4 - Full breathing: blue flashes at 50 percent duty, rate equals respiration rate.
// RQ5 - Full movement tracking: green 0.5 s then blue 0.5 s, repeating.
// RQ6 - Full movement: green 0.5 s then orange 0.5 s, repeating.
// RQ7 - No movement in full or simple: red 0.3 s, dark 4.7 s.
// RQ8 - Simple mode: steady blue breathing, green tracking, orange movement.
// RQ9 - One band bit selects low or high frequency band.
// RQ10 - Noise map controls apply identically to slow and fast maps.
// RQ11 - Stored enabled with valid map: load stored map at start.
// RQ12 - Stored enabled, none valid, default off: build map, save after init.
// RQ13 - Stored map built under a different zone is invalid.
// RQ14 - Stored enabled, none valid, default on: load default map.
// RQ15 - Both off: always build new map, keep stored map untouched.
// RQ16 - Stored off, default on: load default; default off never used.
// RQ17 - Adaptation follows adaptive setting, still suppressed under conditions.
// RQ18 - Defaults: sensitivity 5, full, low band, stored off, default off, adapt on.
// RQ19 - Six states; leaving error needs a profile reload.
// RQ20 - Movement levels valid outside initializing and error.
// RQ21 - Distance, RCS and quality valid in movement, tracking and breathing.
// RQ22 - Respiration data valid only in breathing.
// RQ23 - Fail-safe shows steady white over any mode.
// RQ24 - Pattern timing from clock counter; state or mode change restarts it.
package ssli_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned STEP_MS = 100;
    localparam int unsigned STEP_CYC = CLK_HZ / 1000 * STEP_MS;
    localparam logic [3:0] SENS_MAX = 4'h9;
    localparam logic [3:0] SENS_RST = 4'h5;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic BAND_RST = 1'b0;
    localparam logic USE_STORED_RST = 1'b0;
    localparam logic USE_DEFAULT_RST = 1'b0;
    localparam logic ADAPT_RST = 1'b1;
    localparam logic [2:0] INIT_G1 = 3'h2;
    localparam logic [2:0] INIT_O1 = 3'h4;
    localparam logic [2:0] INIT_R = 3'h7;
    localparam logic [2:0] INIT_O2 = 3'h2;
    localparam logic [5:0] INIT_END = 6'h0E;
    localparam logic [5:0] INIT_B1 = 6'h02;
    localparam logic [5:0] INIT_B2 = 6'h04;
    localparam logic [5:0] INIT_B3 = 6'h07;
    localparam logic [5:0] INIT_B4 = 6'h09;
    localparam logic [5:0] INIT_B5 = 6'h0B;
    localparam logic [5:0] HALF_END = 6'h0A;
    localparam logic [5:0] HALF_B = 6'h05;
    localparam logic [5:0] NOMOV_END = 6'h32;
    localparam logic [5:0] NOMOV_B = 6'h03;
    localparam logic [6:0] RPM_MAX = 7'h7F;
    localparam logic [18:0] HALF_MIN_STEPS = 19'h0012C;
    typedef enum logic [2:0] {
        SSLI_NOMOV = 3'b000,
        SSLI_MOV = 3'b001,
        SSLI_TRACK = 3'b010,
        SSLI_BREATH = 3'b011,
        SSLI_INIT = 3'b100,
        SSLI_ERROR = 3'b101
    } ssli_state_t;
    typedef enum logic [1:0] {
        SSLI_FULL = 2'b00,
        SSLI_SIMPLE = 2'b01,
        SSLI_OFF = 2'b10
    } ssli_mode_t;
    typedef enum logic [1:0] {
        SSLI_MAP_BUILD = 2'b00,
        SSLI_MAP_STORED = 2'b01,
        SSLI_MAP_DEFAULT = 2'b10
    } ssli_map_t;
    typedef struct packed {
        logic red;
        logic green;
        logic blue;
    } ssli_rgb_t;
    typedef struct packed {
        logic [3:0] sensitivity;
        logic [1:0] led_mode;
        logic band_high;
        logic use_stored;
        logic use_default;
        logic adaptive;
    } ssli_settings_t;
    typedef struct packed {
        logic movement;
        logic target;
        logic respiration;
    } ssli_valid_t;
endpackage

// ### bench/ssli_host.sv
// Host model issuing settings writes and profile starts
`timescale 1ns/10ps
module ssli_host (
    input wire logic clock_i,
    output logic set_we_o,
    output ssli_pkg::ssli_settings_t set_data_o,
    output logic profile_start_o
);
    initial
    begin
        set_we_o = 1'h0;
        set_data_o = 10'h3FF;
        profile_start_o = 1'h0;
    end
    // One write per call; released data shows its inverse
    task automatic write(input ssli_pkg::ssli_settings_t data);
        @(negedge clock_i);
        set_we_o = 1'h1;
        set_data_o = data;
        @(negedge clock_i);
        set_we_o = 1'h0;
        set_data_o = ~data;
    endtask
    // Profile reload, also the way out of the error state
    task automatic start();
        @(negedge clock_i);
        profile_start_o = 1'h1;
        @(negedge clock_i);
        profile_start_o = 1'h0;
    endtask
endmodule

// ### bench/ssli_top_asserts.sv
// Checker for the settings, indicator and noise map ports
`timescale 1ns/10ps
module ssli_top_asserts (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic set_we_i,
    input wire ssli_pkg::ssli_settings_t set_data_i,
    input wire logic profile_start_i,
    input wire logic [2:0] state_i,
    input wire logic fail_safe_i,
    input wire logic stored_map_present_i,
    input wire logic [15:0] stored_map_zone_i,
    input wire logic [15:0] zone_cfg_i,
    input wire logic adapt_suppress_i,
    input wire ssli_pkg::ssli_settings_t settings_o,
    input wire logic set_reject_o,
    input wire ssli_pkg::ssli_rgb_t led_o,
    input wire logic band_high_o,
    input wire ssli_pkg::ssli_map_t map_src_slow_o,
    input wire ssli_pkg::ssli_map_t map_src_fast_o,
    input wire logic adapt_en_slow_o,
    input wire logic adapt_en_fast_o,
    input wire logic error_hold_o,
    input wire ssli_pkg::ssli_valid_t valid_o
);
    wire logic bad_wr = set_we_i && (set_data_i.sensitivity > ssli_pkg::SENS_MAX || set_data_i.led_mode == 2'h3);
    wire logic map_ok = stored_map_present_i && (stored_map_zone_i == zone_cfg_i);
    wire ssli_pkg::ssli_map_t exp_src = (settings_o.use_stored && map_ok) ? ssli_pkg::SSLI_MAP_STORED :
        (settings_o.use_default ? ssli_pkg::SSLI_MAP_DEFAULT : ssli_pkg::SSLI_MAP_BUILD);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_off_dark;
        (settings_o.led_mode == 2'h2 && !fail_safe_i)[*3];
    endsequence
    sequence s_fail_held;
        fail_safe_i[*3];
    endsequence
    a_reject_pulse: assert property (bad_wr |=> set_reject_o && $stable(settings_o))
        else $error("invalid write not refused");
    a_write_taken: assert property (set_we_i && !bad_wr |=> !set_reject_o && settings_o == $past(set_data_i))
        else $error("valid write not taken");
    a_band_follow: assert property (band_high_o == settings_o.band_high) else $error("band output differs");
    a_maps_same: assert property (map_src_slow_o == map_src_fast_o && adapt_en_slow_o == adapt_en_fast_o)
        else $error("slow and fast maps differ");
    a_adapt_gate: assert property (adapt_en_slow_o == (settings_o.adaptive && !adapt_suppress_i))
        else $error("adaptation enable wrong");
    a_map_select: assert property (profile_start_i |=> map_src_slow_o == $past(exp_src))
        else $error("noise map source wrong");
    a_off_dark: assert property (s_off_dark |-> led_o == 3'h0) else $error("indicator lit in off mode");
    a_fail_white: assert property (s_fail_held |-> led_o == 3'h7) else $error("fail-safe not white");
    a_error_hold: assert property (state_i == 3'h5 |=> error_hold_o) else $error("error hold not set");
    a_no_resp_data: assert property (state_i != 3'h3 |=> !valid_o.respiration)
        else $error("respiration data outside breathing");
    a_no_move_data: assert property (state_i inside {3'h4, 3'h5} |=> !valid_o.movement)
        else $error("movement data in init or error");
endmodule
bind ssli_top ssli_top_asserts i_asserts (.clock_i, .rst_b_i, .set_we_i, .set_data_i, .profile_start_i, .state_i,
    .fail_safe_i, .stored_map_present_i, .stored_map_zone_i, .zone_cfg_i, .adapt_suppress_i, .settings_o,
    .set_reject_o, .led_o, .band_high_o, .map_src_slow_o, .map_src_fast_o, .adapt_en_slow_o, .adapt_en_fast_o,
    .error_hold_o, .valid_o);

// ### bench/test_ssli_top.sv
// Testbench for the settings, indicator and noise map block
`timescale 1ns/10ps
module test_ssli_top;
    logic clock_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic set_we_i, profile_start_i, fail_safe_i, stored_map_present_i, adapt_suppress_i, set_reject_o;
    logic band_high_o, map_save_o, adapt_en_slow_o, adapt_en_fast_o, error_hold_o;
    logic [2:0] state_i;
    logic [6:0] rpm_i;
    logic [15:0] stored_map_zone_i, zone_cfg_i;
    ssli_pkg::ssli_settings_t set_data_i, settings_o;
    ssli_pkg::ssli_rgb_t led_o;
    ssli_pkg::ssli_map_t map_src_slow_o, map_src_fast_o;
    ssli_pkg::ssli_valid_t valid_o;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int saves;
    logic [6:0] c;
    localparam logic [2:0] LED_EXP [3][5] = '{'{3'h4, 3'h2, 3'h2, 3'h1, 3'h2}, '{3'h4, 3'h6, 3'h2, 3'h1, 3'h2},
        '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0}};
    localparam logic [6:0] MAP_CASE [6] = '{7'h5A, 7'h7A, 7'h51, 7'h64, 7'h18, 7'h3C};
    localparam logic [2:0] VAL_EXP [5] = '{3'h4, 3'h6, 3'h6, 3'h7, 3'h0};
    ssli_host i_host (.clock_i, .set_we_o(set_we_i), .set_data_o(set_data_i), .profile_start_o(profile_start_i));
    ssli_top i_dut (.clock_i, .rst_b_i, .set_we_i, .set_data_i, .profile_start_i, .state_i, .fail_safe_i, .rpm_i,
        .stored_map_present_i, .stored_map_zone_i, .zone_cfg_i, .adapt_suppress_i, .settings_o, .set_reject_o, .led_o,
        .band_high_o, .map_src_slow_o, .map_src_fast_o, .map_save_o, .adapt_en_slow_o, .adapt_en_fast_o,
        .error_hold_o, .valid_o);
    always #12.5 clock_i = ~clock_i;
    function automatic ssli_pkg::ssli_settings_t cfg(input logic [3:0] s, input logic [1:0] m, input logic b,
        input logic st, input logic df, input logic ad);
        return {s, m, b, st, df, ad};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        state_i = 3'h4;
        fail_safe_i = 1'h0;
        rpm_i = 7'h0F;
        stored_map_present_i = 1'h0;
        stored_map_zone_i = 16'h0010;
        zone_cfg_i = 16'h0010;
        adapt_suppress_i = 1'h0;
        repeat (16) @(negedge clock_i);
        rst_b_i = 1'h1;
        repeat (3) @(negedge clock_i);
        chk("defaults", 16'(cfg(4'h5, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1)), 16'(settings_o));
        for (int s = 0; s < 12; s++)
        begin
            i_host.write(cfg(4'(s), 2'h0, 1'h0, 1'h0, 1'h0, 1'h1));
            chk("reject", 16'(s > 9), 16'(set_reject_o));
            chk("sensitivity", 16'(s > 9 ? 9 : s), 16'(settings_o.sensitivity));
        end
        i_host.write(cfg(4'h5, 2'h3, 1'h0, 1'h0, 1'h0, 1'h1));
        chk("mode reject", 16'h0001, 16'(set_reject_o));
        for (int m = 0; m < 3; m++)
            for (int st = 0; st < 5; st++)
            begin
                i_host.write(cfg(4'h5, 2'(m), 1'h0, 1'h0, 1'h0, 1'h1));
                state_i = 3'(st);
                repeat (4) @(negedge clock_i);
                chk("led", 16'(LED_EXP[m][st]), 16'(led_o));
            end
        fail_safe_i = 1'h1;
        repeat (4) @(negedge clock_i);
        chk("fail-safe led", 16'h0007, 16'(led_o));
        fail_safe_i = 1'h0;
        i_host.write(cfg(4'h5, 2'h0, 1'h1, 1'h0, 1'h0, 1'h1));
        chk("band", 16'h0001, 16'(band_high_o));
        for (int a = 0; a < 4; a++)
        begin
            i_host.write(cfg(4'h5, 2'h0, 1'h0, 1'h0, 1'h0, 1'(a >> 1)));
            adapt_suppress_i = 1'(a);
            @(negedge clock_i);
            chk("adapt", 16'(a == 2 ? 3 : 0), 16'({adapt_en_slow_o, adapt_en_fast_o}));
        end
        for (int k = 0; k < 6; k++)
        begin
            c = MAP_CASE[k];
            i_host.write(cfg(4'h5, 2'h0, 1'h0, c[6], c[5], 1'h1));
            stored_map_present_i = c[4];
            stored_map_zone_i = c[3] ? zone_cfg_i : 16'h0077;
            state_i = 3'h4;
            i_host.start();
            chk("map slow", 16'(c[2:1]), 16'(map_src_slow_o));
            chk("map fast", 16'(c[2:1]), 16'(map_src_fast_o));
            saves = 0;
            state_i = 3'h0;
            repeat (5)
            begin
                @(negedge clock_i);
                saves += int'(map_save_o);
            end
            chk("map save", 16'(c[0]), 16'(saves));
        end
        state_i = 3'h5;
        repeat (3) @(negedge clock_i);
        chk("error hold", 16'h0001, 16'(error_hold_o));
        chk("error valid", 16'h0000, 16'(valid_o));
        state_i = 3'h0;
        repeat (3) @(negedge clock_i);
        chk("hold kept", 16'h0001, 16'(error_hold_o));
        i_host.start();
        @(negedge clock_i);
        chk("hold cleared", 16'h0000, 16'(error_hold_o));
        for (int st = 0; st < 5; st++)
        begin
            state_i = 3'(st);
            repeat (3) @(negedge clock_i);
            chk("valid", 16'(VAL_EXP[st]), 16'(valid_o));
        end
        test_done();
    end
endmodule
